/* File: bench/piu_checker.sv */
// concurrent checks on the bus and request ports of the pin interrupt unit
`timescale 1ns/10ps
`include "piu_defines.svh"
module piu_checker import piu_pkg::*; (
  input wire logic clock_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic s_axi_awvalid_i, // write address valid
  input wire logic s_axi_awready_o, // write address ready
  input wire logic s_axi_wvalid_i, // write data valid
  input wire logic s_axi_wready_o, // write data ready
  input wire logic [1:0] s_axi_bresp_o, // write response
  input wire logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic s_axi_arvalid_i, // read address valid
  input wire logic s_axi_arready_o, // read address ready
  input wire logic [31:0] s_axi_rdata_o, // read data
  input wire logic [1:0] s_axi_rresp_o, // read response
  input wire logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic irq_o // interrupt request
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [3:0] hs_age_r; // cycles since last data or read handshake
  // saturating age, so a late request drop cannot hide behind a wrap
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hs_age_r <= 4'hF;
    end else if ((s_axi_wvalid_i && s_axi_wready_o) || (s_axi_arvalid_i && s_axi_arready_o)) begin
      hs_age_r <= 4'h0;
    end else if (hs_age_r != 4'hF) begin
      hs_age_r <= hs_age_r + 4'h1;
    end
  end
  // request only drops shortly after a flag read or an enable clear
  irq_fall_a: assert property ($fell(irq_o) |-> hs_age_r <= 4'h4)
    else $error("request dropped with no bus access");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write answer not two edges after");
  b_blocks_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("new write taken while response pending");
  r_blocks_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("new read taken while data pending");
  ready_back_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> ##1 (s_axi_awready_o && s_axi_wready_o))
    else $error("write slot not free after response");
  slverr_zero_a: assert property (s_axi_rvalid_o && s_axi_rresp_o == `PIU_RESP_SLVERR |-> s_axi_rdata_o == 32'h0)
    else $error("unmapped read returned data");
  irq_up_c: cover property ($rose(irq_o));
  irq_down_c: cover property ($fell(irq_o));
  slverr_c: cover property (s_axi_rvalid_o && s_axi_rresp_o == `PIU_RESP_SLVERR);
endmodule : piu_checker
bind piu_top piu_checker chk (.clock_i, .nrst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);

/* File: bench/piu_cpu_model.sv */
// cpu-side sink: records event pulses and request rises from the unit
`timescale 1ns/10ps
module piu_cpu_model import piu_pkg::*; (
  input wire logic clock_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic irq_i, // level request
  input wire logic [PIU_LINES-1:0] event_i, // event pulses
  output logic [PIU_LINES-1:0] ev_seen_o, // sticky event record
  output logic [7:0] irq_rises_o // request rise count
);
  logic irq_r; // request one cycle back
  // sticky record, so a one-cycle event is never missed by the bench
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_seen_o <= '0;
      irq_r <= 1'b0;
      irq_rises_o <= 8'h00;
    end else begin
      ev_seen_o <= ev_seen_o | event_i;
      irq_r <= irq_i;
      if (irq_i && !irq_r) begin
        irq_rises_o <= irq_rises_o + 8'h01;
      end
    end
  end
endmodule : piu_cpu_model

/* File: bench/tb_top.sv */
// self-checking bench: register access, security, protection and line detection
`timescale 1ns/10ps
`include "piu_defines.svh"
module tb_top import piu_pkg::*;;
  logic clk, nrst, awv, wv, brdy, arv, rrdy, awr, wr_o, bv, arr, rv, irq;
  logic [7:0] awa, ara, pins, ev, ev_seen, rises;
  logic [2:0] awp, arp;
  logic [31:0] wd, rdat, d;
  logic [1:0] br, rr, r;
  int n_mismatch, n_compared;
  piu_top #(.ULP_DIV(8), .GEN_DIV(2)) dut (.clock_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa),
    .s_axi_awprot_i(awp), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ara), .s_axi_arprot_i(arp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy), .line_pin_i(pins), .irq_o(irq), .event_o(ev));
  piu_cpu_model cpu (.clock_i(clk), .nrst_i(nrst), .irq_i(irq), .event_i(ev), .ev_seen_o(ev_seen),
    .irq_rises_o(rises));
  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one write; address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic ns);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    awa <= a;
    wd <= v;
    awp <= {1'b0, ns, 1'b0};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (!a_ok && awr) begin
        a_ok = 1'b1;
        awv <= 1'b0;
      end
      if (!w_ok && wr_o) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    brdy <= 1'b1;
    @(posedge clk);
    r = br;
    brdy <= 1'b0;
  endtask : wr
  // one read; data and response taken at the handshake edge
  task automatic rd(input logic [7:0] a, input logic ns, output logic [31:0] v, output logic [1:0] e);
    ara <= a;
    arp <= {1'b0, ns, 1'b0};
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rrdy <= 1'b1;
    @(posedge clk);
    v = rdat;
    e = rr;
    rrdy <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic ns, input logic [31:0] e);
    rd(a, ns, d, r);
    chk(d, e);
  endtask : rc
  // bounded wait for the request to reach a level
  task automatic irq_by(input int n, input logic want);
    for (int i = 0; i < n && irq !== want; i++) @(posedge clk);
    chk({31'h0, irq}, {31'h0, want});
  endtask : irq_by
  // pin change, then a quiet span with no request expected
  task automatic pin_quiet(input logic [7:0] v, input int n);
    @(posedge clk);
    pins <= v;
    repeat (n) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask : pin_quiet
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {nrst, awv, wv, brdy, arv, rrdy} = '0;
    {awa, ara, pins, awp, arp, wd} = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // shared enable state through set and clear views
    rc(`PIU_OFF_IEN_CLR, 1'b0, 32'h0);
    wr(`PIU_OFF_IEN_SET, 32'h8000_0003, 1'b0);
    rc(`PIU_OFF_IEN_CLR, 1'b0, 32'h8000_0003);
    wr(`PIU_OFF_IEN_CLR, 32'h0, 1'b0);
    rc(`PIU_OFF_IEN_CLR, 1'b0, 32'h8000_0003);
    wr(`PIU_OFF_IEN_CLR, 32'h8000_0001, 1'b0);
    rc(`PIU_OFF_IEN_CLR, 1'b0, 32'h0000_0002);
    // line 1 non-secure, line 0 secured
    wr(`PIU_OFF_SECATTR, 32'h02, 1'b0);
    wr(`PIU_OFF_IEN_SET, 32'h01, 1'b0);
    wr(`PIU_OFF_IEN_CLR, 32'h03, 1'b1);
    rc(`PIU_OFF_IEN_CLR, 1'b0, 32'h01);
    wr(`PIU_OFF_IEN_SET, 32'h02, 1'b0);
    rc(`PIU_OFF_IEN_CLR, 1'b1, 32'h02);
    wr(`PIU_OFF_CONFIG, 32'h315, 1'b1);
    chk({30'h0, r}, {30'h0, `PIU_RESP_OKAY});
    rc(`PIU_OFF_CONFIG, 1'b0, 32'h10);
    wr(`PIU_OFF_ASYNC, 32'h02, 1'b0);
    wr(`PIU_OFF_EVENT_OUTPUT_CONTROL, 32'h02, 1'b0);
    rd(8'h40, 1'b0, d, r);
    chk({d[29:0], r}, {30'h0, `PIU_RESP_SLVERR});
    wr(8'h40, 32'h0, 1'b0);
    chk({30'h0, r}, {30'h0, `PIU_RESP_SLVERR});
    pin_quiet(8'h02, 10);
    pin_quiet(8'h00, 4);
    // enabled: rising edge on line 1 raises request and event
    wr(`PIU_OFF_CTRL, 32'h02, 1'b0);
    @(posedge clk);
    pins <= 8'h02;
    irq_by(20, 1'b1);
    rc(`PIU_OFF_FLAGS, 1'b0, 32'h02);
    irq_by(3, 1'b0);
    // protected settings refuse writes while enabled
    wr(`PIU_OFF_CONFIG, 32'h0, 1'b0);
    rc(`PIU_OFF_CONFIG, 1'b0, 32'h10);
    wr(`PIU_OFF_ASYNC, 32'h0, 1'b0);
    rc(`PIU_OFF_ASYNC, 1'b0, 32'h02);
    wr(`PIU_OFF_CTRL, 32'h12, 1'b0);
    rc(`PIU_OFF_CTRL, 1'b0, 32'h02);
    // masked line still flags but raises no request
    wr(`PIU_OFF_IEN_CLR, 32'h02, 1'b0);
    pin_quiet(8'h00, 4);
    pin_quiet(8'h02, 20);
    rc(`PIU_OFF_FLAGS, 1'b0, 32'h02);
    // filtered level line on the low-power tick
    wr(`PIU_OFF_CTRL, 32'h0, 1'b0);
    wr(`PIU_OFF_CTRL, 32'h10, 1'b0);
    rc(`PIU_OFF_CTRL, 1'b0, 32'h10);
    wr(`PIU_OFF_CONFIG, 32'hC10, 1'b0);
    wr(`PIU_OFF_IEN_SET, 32'h04, 1'b0);
    wr(`PIU_OFF_CTRL, 32'h12, 1'b0);
    @(posedge clk);
    pins <= 8'h06;
    irq_by(300, 1'b1);
    rd(`PIU_OFF_FLAGS, 1'b0, d, r);
    chk({31'h0, d[2]}, 32'h1);
    chk({24'h0, ev_seen}, 32'h02);
    chk({24'h0, rises}, 32'h02);
    report_and_stop();
  end
endmodule : tb_top

/* File: rtl/piu_defines.svh */
// register offsets, field positions, sense and response codes and timing figures of the pin interrupt unit
// Contract
// [R01] detect configured edge or level, raise request/event
// [R02] optional majority filter on generic or 32k tick
// [R03] software follows the documented bring-up order
// [R04] software enables filter clock when filtering used
// [R05] generic clock chosen when faster sampling needed
// [R06] clock-select one picks the low-power 32k clock
// [R07] unit works only after enable written one
// [R08] clock-select writable only while disabled
// [R09] event, config, async registers writable only disabled
// [R10] non-secure writes to secured lines silently dropped
// [R11] non-secure enable-clear access only for non-secure lines
// [R12] enable set and clear share one state
// [R13] one to check bit clears it, zero ignored
// [R14] low byte reads enables, one clears, zero ignored
// [R15] request only while pending and enabled both set
`ifndef PIU_DEFINES_SVH
`define PIU_DEFINES_SVH
`define PIU_CLK_HZ 200000000
`define PIU_ULP_HZ 32768
`define PIU_GEN_DIV 4
`define PIU_OFF_CTRL 8'h00
`define PIU_OFF_EVENT_OUTPUT_CONTROL 8'h04
`define PIU_OFF_ASYNC 8'h08
`define PIU_OFF_IEN_CLR 8'h0C
`define PIU_OFF_IEN_SET 8'h10
`define PIU_OFF_FLAGS 8'h14
`define PIU_OFF_CONFIG 8'h18
`define PIU_OFF_DEBOUNCE 8'h1C
`define PIU_OFF_SECATTR 8'h20
`define PIU_BIT_ENABLE 1
`define PIU_BIT_FILTER_CLOCK_SELECT 4
`define PIU_BIT_NONSECURE_CHECK_IRQ 31
`define PIU_CFG_FILT 3
`define PIU_SENSE_NONE 3'h0
`define PIU_SENSE_RISE 3'h1
`define PIU_SENSE_FALL 3'h2
`define PIU_SENSE_BOTH 3'h3
`define PIU_SENSE_HIGH 3'h4
`define PIU_SENSE_LOW 3'h5
`define PIU_DEB_TICKS 2'h3
`define PIU_RESP_OKAY 2'h0
`define PIU_RESP_SLVERR 2'h2
`endif

/* File: rtl/piu_line_detect.sv */
// per-line sampling, majority filter, debouncer and sense detection
`timescale 1ns/10ps
`include "piu_defines.svh"
module piu_line_detect import piu_pkg::*; (
  input wire logic clock_i, // system clock
  input wire logic nrst_i, // async reset, active low
  piu_line_if.line lif // configuration in, detections out
);
  // majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction : maj3

  genvar gi;
  generate
    for (gi = 0; gi < PIU_LINES; gi++) begin : g_line
      logic [2:0] samp_r; // tick-sampled history
      logic stable_r; // debounced level
      logic [1:0] deb_cnt_r; // ticks the level has differed
      logic prev_r; // level one clock earlier
      logic det_r; // detection pulse
      logic filtered; // sampled level after optional vote
      logic level; // level fed to sense logic
      assign filtered = lif.filt[gi] ? maj3(samp_r) : samp_r[0]; // [R02]
      // async path skips sampling, so it sees short pulses but no filter
      assign level = lif.asyn[gi] ? lif.pin[gi] : (lif.deb[gi] ? stable_r : filtered);

      // sample history advances on the filter tick only
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          samp_r <= '0;
        end else if (lif.tick) begin
          samp_r <= {samp_r[1:0], lif.pin[gi]}; // [R02]
        end
      end

      // debouncer: a new level must persist for several ticks
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          stable_r <= 1'b0;
          deb_cnt_r <= '0;
        end else if (lif.tick) begin
          if (filtered == stable_r) begin
            deb_cnt_r <= '0; // bounce back, restart
          end else if (deb_cnt_r == `PIU_DEB_TICKS - 2'h1) begin
            stable_r <= filtered;
            deb_cnt_r <= '0;
          end else begin
            deb_cnt_r <= deb_cnt_r + 2'h1;
          end
        end
      end

      // sense decode, gated by the unit enable
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          prev_r <= 1'b0;
          det_r <= 1'b0;
        end else begin
          prev_r <= level;
          case (lif.sense[gi])
            `PIU_SENSE_RISE: det_r <= lif.enable & level & ~prev_r; // [R01]
            `PIU_SENSE_FALL: det_r <= lif.enable & ~level & prev_r; // [R01]
            `PIU_SENSE_BOTH: det_r <= lif.enable & (level ^ prev_r); // [R01]
            `PIU_SENSE_HIGH: det_r <= lif.enable & level; // [R01]
            `PIU_SENSE_LOW: det_r <= lif.enable & ~level; // [R01]
            default: det_r <= 1'b0; // none or reserved code
          endcase
        end
      end
      assign lif.detect[gi] = det_r;
    end
  endgenerate
endmodule : piu_line_detect

/* File: rtl/piu_line_if.sv */
// carrier between register side and line detection logic
`timescale 1ns/10ps
interface piu_line_if;
  import piu_pkg::*;
  piu_lines_t pin; // raw line levels
  logic enable; // unit enabled
  logic tick; // filter sample tick
  piu_sense_vec_t sense; // sense code per line
  piu_lines_t filt; // majority filter select
  piu_lines_t asyn; // asynchronous path select
  piu_lines_t deb; // debounce select
  piu_lines_t detect; // detections, one-cycle for edge senses, held for level senses
  modport ctrl (output pin, enable, tick, sense, filt, asyn, deb, input detect);
  modport line (input pin, enable, tick, sense, filt, asyn, deb, output detect);
endinterface : piu_line_if

/* File: rtl/piu_pkg.sv */
// shared types of the pin interrupt unit
package piu_pkg;
  localparam int PIU_LINES = 8; // number of external lines
  typedef logic [PIU_LINES-1:0] piu_lines_t; // one bit per line
  typedef logic [2:0] piu_sense_t; // sense code of one line
  typedef piu_sense_t [PIU_LINES-1:0] piu_sense_vec_t; // sense codes of all lines
endpackage : piu_pkg

/* File: rtl/piu_top.sv */
// pin interrupt unit top: axi4-lite registers, filter tick, flags, request and events
`timescale 1ns/10ps
`include "piu_defines.svh"
module piu_top import piu_pkg::*; #(
  parameter int ULP_DIV = `PIU_CLK_HZ / `PIU_ULP_HZ, // clocks per low-power tick
  parameter int GEN_DIV = `PIU_GEN_DIV // clocks per generic tick
) (
  input wire logic clock_i, // system clock, 200 mhz
  input wire logic nrst_i, // async reset, active low
  input wire logic [7:0] s_axi_awaddr_i, // write address
  input wire logic [2:0] s_axi_awprot_i, // write protection, bit 1 non-secure
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [7:0] s_axi_araddr_i, // read address
  input wire logic [2:0] s_axi_arprot_i, // read protection, bit 1 non-secure
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic [PIU_LINES-1:0] line_pin_i, // external line levels
  output logic irq_o, // interrupt request, level
  output logic [PIU_LINES-1:0] event_o // event pulses per line
);
  // byte strobes to a 32-bit bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // replace the bits under mask m
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // decode of mapped offsets, used on both address channels
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `PIU_OFF_CTRL, `PIU_OFF_EVENT_OUTPUT_CONTROL, `PIU_OFF_ASYNC, `PIU_OFF_IEN_CLR, `PIU_OFF_IEN_SET,
      `PIU_OFF_FLAGS, `PIU_OFF_CONFIG, `PIU_OFF_DEBOUNCE, `PIU_OFF_SECATTR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // bus-side state
  logic awready_r; // address slot free
  logic wready_r; // data slot free
  logic aw_held_r; // address captured
  logic w_held_r; // data captured
  logic [7:0] waddr_r; // captured write address
  logic wns_r; // captured write is non-secure
  logic [31:0] wdata_r; // captured write data
  logic [3:0] wstrb_r; // captured strobes
  logic bvalid_r; // write response pending
  logic [1:0] bresp_r; // write response code
  logic arready_r; // read address slot free
  logic rvalid_r; // read data pending
  logic [31:0] rdata_r; // read data
  logic [1:0] rresp_r; // read response code

  // register state
  logic enable_r; // unit enable
  logic filter_clock_select_r; // tick source: 1 low-power 32k
  piu_lines_t event_output_control_r; // event output enables
  piu_lines_t async_r; // asynchronous path selects
  piu_lines_t debounce_r; // debounce selects
  logic [31:0] config_r; // four bits per line
  piu_lines_t line_security_attribution_r; // 1 marks a line non-secure
  piu_lines_t ien_r; // line interrupt enables
  logic nonsecure_check_irq_en_r; // non-secure check enable
  piu_lines_t flags_r; // sticky pending flags
  logic irq_r; // registered request
  piu_lines_t event_r; // registered event pulses

  // tick generator
  logic [15:0] div_cnt_r; // divider count
  logic tick_r; // one-cycle sample tick
  logic [15:0] div_top; // terminal count of selected source

  // write and read decode
  logic do_write; // address and data both held
  logic rd_take; // read address handshake
  logic [31:0] wmask; // strobe mask
  piu_lines_t lmask; // lines this write may touch
  logic [31:0] cfg_lmask; // same, widened to config nibbles
  logic glob_ok; // write may touch global settings
  logic [31:0] rd_val; // read mux output
  piu_lines_t rd_lmask; // lines this read may see
  piu_lines_t flag_clr; // lines cleared by the read

  piu_line_if lif(); // carrier to detection logic

  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign rd_take = s_axi_arvalid_i & arready_r;
  assign wmask = strb_mask(wstrb_r);
  assign lmask = wns_r ? line_security_attribution_r : {PIU_LINES{1'b1}}; // [R10]
  // shared settings belong to every line, so non-secure may only touch them when no line is secured
  assign glob_ok = ~wns_r | (&line_security_attribution_r); // [R10]
  assign rd_lmask = s_axi_arprot_i[1] ? line_security_attribution_r : {PIU_LINES{1'b1}}; // [R11]

  genvar gi;
  generate
    for (gi = 0; gi < PIU_LINES; gi++) begin : g_cfg
      assign cfg_lmask[4*gi +: 4] = {4{lmask[gi]}};
      assign lif.sense[gi] = config_r[4*gi +: 3];
      assign lif.filt[gi] = config_r[4*gi + `PIU_CFG_FILT];
    end
  endgenerate

  assign lif.pin = line_pin_i;
  assign lif.enable = enable_r;
  assign lif.tick = tick_r;
  assign lif.asyn = async_r;
  assign lif.deb = debounce_r;

  piu_line_detect u_detect (
    .clock_i (clock_i),
    .nrst_i (nrst_i),
    .lif (lif.line)
  );

  // filter tick: generic divider or low-power divider picked by filter_clock_select
  assign div_top = filter_clock_select_r ? 16'(ULP_DIV - 1) : 16'(GEN_DIV - 1); // [R02] [R06]
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= div_top) begin
      div_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // write address channel, taken independently of data
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      waddr_r <= '0;
      wns_r <= 1'b0;
    end else if (s_axi_awvalid_i && awready_r) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      waddr_r <= s_axi_awaddr_i;
      wns_r <= s_axi_awprot_i[1];
    end else if (do_write) begin
      aw_held_r <= 1'b0; // slot reopens after the response
    end else if (!aw_held_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid_i && wready_r) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata_i;
      wstrb_r <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end else if (!w_held_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // write response; dropped secure writes still answer okay
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PIU_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= is_mapped(waddr_r) ? `PIU_RESP_OKAY : `PIU_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // main control: enable writable in either state, filter_clock_select only while disabled; non-secure writes need every line non-secure
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_r <= 1'b0;
      filter_clock_select_r <= 1'b0;
    end else if (do_write && waddr_r == `PIU_OFF_CTRL && glob_ok) begin
      if (wstrb_r[0]) begin
        enable_r <= wdata_r[`PIU_BIT_ENABLE]; // [R07]
        if (!enable_r) begin
          filter_clock_select_r <= wdata_r[`PIU_BIT_FILTER_CLOCK_SELECT]; // [R08]
        end
      end
    end
  end

  // enable-protected line settings; debounce select is not protected
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_output_control_r <= '0;
      async_r <= '0;
      config_r <= '0;
      debounce_r <= '0;
    end else if (do_write) begin
      if (waddr_r == `PIU_OFF_EVENT_OUTPUT_CONTROL && !enable_r) begin
        event_output_control_r <= (event_output_control_r & ~(wmask[7:0] & lmask)) | (wdata_r[7:0] & wmask[7:0] & lmask); // [R09] [R10]
      end
      if (waddr_r == `PIU_OFF_ASYNC && !enable_r) begin
        async_r <= (async_r & ~(wmask[7:0] & lmask)) | (wdata_r[7:0] & wmask[7:0] & lmask); // [R09] [R10]
      end
      if (waddr_r == `PIU_OFF_CONFIG && !enable_r) begin
        config_r <= merge(config_r, wdata_r, wmask & cfg_lmask); // [R09] [R10]
      end
      if (waddr_r == `PIU_OFF_DEBOUNCE) begin
        debounce_r <= (debounce_r & ~(wmask[7:0] & lmask)) | (wdata_r[7:0] & wmask[7:0] & lmask); // [R10]
      end
    end
  end

  // security attribution, written only by secure accesses, read unmasked by both
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_security_attribution_r <= '0;
    end else if (do_write && waddr_r == `PIU_OFF_SECATTR && !wns_r) begin
      line_security_attribution_r <= (line_security_attribution_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]); // [R10]
    end
  end

  // one enable state behind both set and clear views, so no read-modify-write is needed
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ien_r <= '0;
      nonsecure_check_irq_en_r <= 1'b0;
    end else if (do_write) begin
      if (waddr_r == `PIU_OFF_IEN_CLR) begin
        ien_r <= ien_r & ~(wdata_r[7:0] & wmask[7:0] & lmask); // [R11] [R12] [R14]
        if (wstrb_r[3] && wdata_r[`PIU_BIT_NONSECURE_CHECK_IRQ] && glob_ok) begin
          nonsecure_check_irq_en_r <= 1'b0; // [R13]
        end
      end else if (waddr_r == `PIU_OFF_IEN_SET) begin
        ien_r <= ien_r | (wdata_r[7:0] & wmask[7:0] & lmask); // [R10] [R12]
        if (wstrb_r[3] && wdata_r[`PIU_BIT_NONSECURE_CHECK_IRQ] && glob_ok) begin
          nonsecure_check_irq_en_r <= 1'b1;
        end
      end
    end
  end

  // read mux; non-secure reads see only non-secure lines, except in the security attribution
  always_comb begin
    rd_val = '0;
    case (s_axi_araddr_i)
      `PIU_OFF_CTRL: begin
        rd_val[`PIU_BIT_ENABLE] = enable_r;
        rd_val[`PIU_BIT_FILTER_CLOCK_SELECT] = filter_clock_select_r;
      end
      `PIU_OFF_EVENT_OUTPUT_CONTROL: rd_val[7:0] = event_output_control_r & rd_lmask;
      `PIU_OFF_ASYNC: rd_val[7:0] = async_r & rd_lmask;
      `PIU_OFF_IEN_CLR, `PIU_OFF_IEN_SET: begin
        rd_val[7:0] = ien_r & rd_lmask; // [R11] [R12] [R14]
        rd_val[`PIU_BIT_NONSECURE_CHECK_IRQ] = nonsecure_check_irq_en_r;
      end
      `PIU_OFF_FLAGS: rd_val[7:0] = flags_r & rd_lmask;
      `PIU_OFF_CONFIG: begin
        for (int i = 0; i < PIU_LINES; i++) begin
          rd_val[4*i +: 4] = config_r[4*i +: 4] & {4{rd_lmask[i]}};
        end
      end
      `PIU_OFF_DEBOUNCE: rd_val[7:0] = debounce_r & rd_lmask;
      `PIU_OFF_SECATTR: rd_val[7:0] = line_security_attribution_r;
      default: rd_val = '0; // unmapped reads as zero with slverr
    endcase
  end

  // read channel, data sampled at the address handshake
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `PIU_RESP_OKAY;
    end else if (rd_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= is_mapped(s_axi_araddr_i) ? `PIU_RESP_OKAY : `PIU_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // pending flags: read clears, but a detection in the same cycle wins
  assign flag_clr = (rd_take && s_axi_araddr_i == `PIU_OFF_FLAGS) ? rd_lmask : '0;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | lif.detect; // [R01]
    end
  end

  // request and events, registered so the outputs come straight from flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r <= 1'b0;
      event_r <= '0;
    end else begin
      irq_r <= |(flags_r & ien_r); // [R15]
      event_r <= lif.detect & event_output_control_r; // [R01]
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign irq_o = irq_r;
  assign event_o = event_r;
endmodule : piu_top
